//--- rtl/port_map_pkg.sv
// Constants for the port to serial lane mapper.
package port_map_pkg;
  localparam int NUM_PORTS = 65;
  localparam int NUM_LANES = 33;
  localparam int PORT_W = 7;
  localparam int LANE_W = 6;
  localparam int NUM_QUAD = 12;
  localparam int NUM_OCTAL = 6;
  localparam int NUM_MULTI = 33;
  localparam logic [PORT_W-1:0] FIXED_PORT = 7'h0040;
  localparam logic [LANE_W-1:0] FIXED_LANE = 6'h00;
  localparam logic [PORT_W-1:0] NO_PORT = 7'h007F;
  localparam logic [PORT_W-1:0] CPU_PORT_A = 7'h0041;
  localparam logic [PORT_W-1:0] CPU_PORT_B = 7'h0042;
  localparam logic [PORT_W-1:0] VD_MCAST = 7'h0043;
  localparam logic [PORT_W-1:0] VD_INJECTOR = 7'h0044;
  localparam logic [PORT_W-1:0] VD_TUNNEL = 7'h0045;
  localparam int QUAD_LANE0 = 13;
  localparam int OCTAL_LANE0 = 17;
  localparam int QUAD_SIZE = 4;
  localparam int OCTAL_SIZE = 8;
  localparam int FIBER_LO = 1;
  localparam int FIBER_HI = 24;
  localparam int FAST_LANE0 = 13;
  localparam int LOW_LANE_LAST = 12;
  localparam int QUAD_DIRECT_LAST = 16;
  localparam int MID_LANE_LAST = 24;
  localparam int LAST_LANE = 32;
  localparam int LOW_PORT_SHIFT = 1;
  localparam int HIGH_PORT_SHIFT = 31;
  localparam int SLOW_PORT_LO = 16;
  localparam int SLOW_PORT_HI = 47;
  localparam int FIVE_PORT_LAST = 11;
  localparam int CAP_PORT_LO = 56;
  localparam int CAP_PORT_HI = 63;
  localparam int SRC_W = 3;
  localparam int CLASS_W = 2;
  typedef enum logic [1:0] {SPEED_2G5, SPEED_5G, SPEED_10G} speed_class_t;
  typedef enum logic [2:0] {SRC_NONE, SRC_FAST, SRC_SHADOW, SRC_QUAD, SRC_OCTAL, SRC_MULTI}
    lane_src_t;
  localparam logic [2:0] MULTI_DXG5 = 3'h1;
endpackage

//--- rtl/port_to_serdes_mapper.sv
// Static mapping of logical ports and port modules onto serial lanes.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - 65 ports, 33 lanes.
// - Port 64 fixed on lane 0.
// - Ports 0-47 can also reach lanes via extenders.
// - Thirty-two ports map one-to-one by default.
// - Ports 65-69 internal, no lane.
// - Speed class per port range.
// - Ports 56-63 limited to ten gigabits.
// - Fast ports have a shadow low-speed module.
// - Shadow select one routes shadow module.
// - Dual 5G multi-rate ignores shadow select.
// - Lane maximum speed per lane range.
// - Fiber 100M only lanes 1-24, direct port.
// - Default port to lane assignment table.
// - Ports 16-47 unconnected by default.
// - Ports 65, 66 are CPU ports.
// - Port 67 is multicast virtual device.
// - Port 68 is injector virtual device.
// - Port 69 is tunnel virtual device.
// - Extender mode removes default lane connection.
// - Priority multi-rate, then octal, then quad.
module port_to_serdes_mapper (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic [64:0]           shadow_select_field,
  input  wire logic [11:0]           quad_ena,
  input  wire logic [5:0]            octal_ena,
  input  wire logic [32:0]           multi_ena,
  input  wire logic [98:0]           multi_mode,
  input  wire logic [32:0]           fiber_100m_req,
  output logic      [230:0]          lane_port,
  output logic      [98:0]           lane_src,
  output logic      [65:0]           lane_speed_max,
  output logic      [32:0]           fiber_100m_mode,
  output logic      [64:0]           shadow_active,
  output logic      [64:0]           port_connected,
  output logic      [129:0]          port_speed_class,
  output logic      [64:0]           port_rate_cap_10g,
  output logic      [34:0]           internal_port_id
);
  //////////////////////////////////////////////////////////////////////////////
  // Lane group next values.
  logic [230:0]       next_lane_port;
  logic [98:0]        next_lane_src;
  logic [65:0]        next_lane_speed_max;
  logic [32:0]        next_fiber;
  // Port group next values.
  logic [64:0]        next_shadow;
  logic [64:0]        next_conn;
  logic [129:0]       next_speed;
  logic [64:0]        next_cap;
  // Internal port group next value.
  logic [34:0]        next_internal;
  // Each lane and port drives its own slice here, so no bit has two drivers.
  wire logic [230:0]  lane_prt_w;
  wire logic [98:0]   lane_src_w;
  wire logic [65:0]   lane_max_w;
  wire logic [32:0]   lane_fiber_w;
  wire logic [32:0]   lane_shadow_w;
  wire logic [2144:0] lane_conn_w;
  wire logic [129:0]  port_speed_w;
  wire logic [64:0]   port_cap_w;

  //////////////////////////////////////////////////////////////////////////////
  // Direct port of a lane; the map is fixed, so every call folds to a constant.
  function automatic logic [6:0] direct_port(input int lane);
    logic [6:0] p;
    p = port_map_pkg::NO_PORT;
    if (lane == int'(port_map_pkg::FIXED_LANE)) begin
      p = port_map_pkg::FIXED_PORT;
    end else if (lane <= port_map_pkg::LOW_LANE_LAST) begin
      p = 7'(lane - port_map_pkg::LOW_PORT_SHIFT);
    end else if (lane <= port_map_pkg::QUAD_DIRECT_LAST) begin
      p = 7'(lane - port_map_pkg::LOW_PORT_SHIFT);
    end else if (lane <= port_map_pkg::MID_LANE_LAST) begin
      p = 7'(lane + port_map_pkg::HIGH_PORT_SHIFT);
    end else if (lane <= port_map_pkg::LAST_LANE) begin
      p = 7'(lane + port_map_pkg::HIGH_PORT_SHIFT);
    end
    return p;
  endfunction

  // First port of the quad extender on a lane, zero where the lane has none.
  function automatic int quad_base(input int lane);
    int b;
    b = 0;
    if (lane >= port_map_pkg::QUAD_LANE0 &&
        lane < port_map_pkg::QUAD_LANE0 + port_map_pkg::NUM_QUAD) begin
      b = (lane - port_map_pkg::QUAD_LANE0) * port_map_pkg::QUAD_SIZE;
    end
    return b;
  endfunction

  // First port of the octal extender on a lane, zero where the lane has none.
  function automatic int octal_base(input int lane);
    int b;
    b = 0;
    if (lane >= port_map_pkg::OCTAL_LANE0 &&
        lane < port_map_pkg::OCTAL_LANE0 + port_map_pkg::NUM_OCTAL) begin
      b = (lane - port_map_pkg::OCTAL_LANE0) * port_map_pkg::OCTAL_SIZE;
    end
    return b;
  endfunction

  // Top speed of a lane, fixed by its macro flavour.
  function automatic port_map_pkg::speed_class_t lane_class(input int lane);
    port_map_pkg::speed_class_t c;
    c = port_map_pkg::SPEED_10G;
    if (lane < port_map_pkg::FAST_LANE0) begin
      c = port_map_pkg::SPEED_5G;
    end
    return c;
  endfunction

  // Speed class of a port, fixed by the module family behind it.
  function automatic port_map_pkg::speed_class_t port_class(input int port);
    port_map_pkg::speed_class_t c;
    c = port_map_pkg::SPEED_10G;
    if (port >= port_map_pkg::SLOW_PORT_LO && port <= port_map_pkg::SLOW_PORT_HI) begin
      c = port_map_pkg::SPEED_2G5;
    end else if (port <= port_map_pkg::FIVE_PORT_LAST) begin
      c = port_map_pkg::SPEED_5G;
    end else if (port == int'(port_map_pkg::FIXED_PORT)) begin
      c = port_map_pkg::SPEED_5G;
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // one slice per lane
  for (genvar gl = 0; gl < port_map_pkg::NUM_LANES; gl++) begin : g_lane
    localparam logic [6:0] DP = direct_port(gl);
    localparam int         QB = quad_base(gl);
    localparam int         OB = octal_base(gl);
    logic                  quad_hit;
    logic                  octal_hit;
    logic                  multi_hit;
    logic [2:0]            src;
    logic [6:0]            prt;
    logic [64:0]           conn;
    logic                  shadow_on;
    logic                  fiber_ok;

    if (gl >= port_map_pkg::QUAD_LANE0 &&
        gl < port_map_pkg::QUAD_LANE0 + port_map_pkg::NUM_QUAD) begin : g_quad
      assign quad_hit = quad_ena[gl - port_map_pkg::QUAD_LANE0];
    end else begin : g_no_quad
      assign quad_hit = 1'b0;
    end
    if (gl >= port_map_pkg::OCTAL_LANE0 &&
        gl < port_map_pkg::OCTAL_LANE0 + port_map_pkg::NUM_OCTAL) begin : g_octal
      assign octal_hit = octal_ena[gl - port_map_pkg::OCTAL_LANE0];
    end else begin : g_no_octal
      assign octal_hit = 1'b0;
    end
    // Lane zero is immune to every extender.
    if (gl == int'(port_map_pkg::FIXED_LANE)) begin : g_no_multi
      assign multi_hit = 1'b0;
    end else begin : g_multi
      assign multi_hit = multi_ena[gl];
    end

    always_comb begin
      prt = DP;
      if (shadow_select_field[DP]) begin
        src = port_map_pkg::SRC_SHADOW;
      end else begin
        src = port_map_pkg::SRC_FAST;
      end
      conn = '0;
      // extenders replace direct; later test wins
      if (quad_hit) begin
        src = port_map_pkg::SRC_QUAD;
        prt = 7'(QB);
      end
      if (octal_hit) begin
        src = port_map_pkg::SRC_OCTAL;
        prt = 7'(OB);
      end
      // multi-rate keeps the direct port and bypasses the shadow
      if (multi_hit) begin
        src = port_map_pkg::SRC_MULTI;
        prt = DP;
      end
      // ports 16-47 linked only through extenders
      if (src == port_map_pkg::SRC_QUAD) begin
        conn[QB +: port_map_pkg::QUAD_SIZE] = '1;
      end else if (src == port_map_pkg::SRC_OCTAL) begin
        conn[OB +: port_map_pkg::OCTAL_SIZE] = '1;
      end else begin
        conn[DP] = 1'b1;
      end
    end

    assign shadow_on = (src == port_map_pkg::SRC_SHADOW);
    if (gl >= port_map_pkg::FIBER_LO && gl <= port_map_pkg::FIBER_HI) begin : g_fiber
      assign fiber_ok = fiber_100m_req[gl] &&
        (src == port_map_pkg::SRC_FAST || src == port_map_pkg::SRC_SHADOW);
    end else begin : g_no_fiber
      assign fiber_ok = 1'b0;
    end

    assign lane_prt_w[port_map_pkg::PORT_W*gl +: port_map_pkg::PORT_W] = prt;
    assign lane_src_w[port_map_pkg::SRC_W*gl +: port_map_pkg::SRC_W] = src;
    assign lane_max_w[port_map_pkg::CLASS_W*gl +: port_map_pkg::CLASS_W] = lane_class(gl);
    assign lane_fiber_w[gl] = fiber_ok;
    assign lane_shadow_w[gl] = shadow_on;
    assign lane_conn_w[port_map_pkg::NUM_PORTS*gl +: port_map_pkg::NUM_PORTS] = conn;
  end

  //////////////////////////////////////////////////////////////////////////////
  // speed class and rate cap per port
  for (genvar gp = 0; gp < port_map_pkg::NUM_PORTS; gp++) begin : g_port
    assign port_speed_w[port_map_pkg::CLASS_W*gp +: port_map_pkg::CLASS_W] = port_class(gp);
    assign port_cap_w[gp] = (gp >= port_map_pkg::CAP_PORT_LO &&
                             gp <= port_map_pkg::CAP_PORT_HI);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lane group.
  always_comb begin
    next_lane_port = lane_prt_w;
    next_lane_src = lane_src_w;
    next_lane_speed_max = lane_max_w;
    next_fiber = lane_fiber_w;
  end

  // Port group. An extender lane and a direct lane may both claim one port;
  // the OR keeps that port shown as connected either way.
  always_comb begin
    next_shadow = '0;
    next_conn = '0;
    for (int l = 0; l < port_map_pkg::NUM_LANES; l++) begin
      next_shadow[direct_port(l)] = next_shadow[direct_port(l)] | lane_shadow_w[l];
      next_conn = next_conn | lane_conn_w[port_map_pkg::NUM_PORTS*l +: port_map_pkg::NUM_PORTS];
    end
    next_speed = port_speed_w;
    next_cap = port_cap_w;
  end

  // Internal port group.
  always_comb begin
    next_internal = {port_map_pkg::VD_TUNNEL, port_map_pkg::VD_INJECTOR,
                     port_map_pkg::VD_MCAST, port_map_pkg::CPU_PORT_B,
                     port_map_pkg::CPU_PORT_A};
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset clears map
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lane_port <= '0;
      lane_src <= '0;
      lane_speed_max <= '0;
      fiber_100m_mode <= '0;
    end else begin
      lane_port <= next_lane_port;
      lane_src <= next_lane_src;
      lane_speed_max <= next_lane_speed_max;
      fiber_100m_mode <= next_fiber;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shadow_active <= '0;
      port_connected <= '0;
      port_speed_class <= '0;
      port_rate_cap_10g <= '0;
    end else begin
      shadow_active <= next_shadow;
      port_connected <= next_conn;
      port_speed_class <= next_speed;
      port_rate_cap_10g <= next_cap;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      internal_port_id <= '0;
    end else begin
      internal_port_id <= next_internal;
    end
  end
endmodule
`default_nettype wire

//--- tb/mapper_chk.sv
// Routing, internal id and rate cap checks on the mapper outputs.
`timescale 1ns/1ns
`default_nettype none
module mapper_chk (
  input wire logic         sys_clk,
  input wire logic         rstn,
  input wire logic [64:0]  shadow_select_field,
  input wire logic [11:0]  quad_ena,
  input wire logic [5:0]   octal_ena,
  input wire logic [32:0]  multi_ena,
  input wire logic [230:0] lane_port,
  input wire logic [98:0]  lane_src,
  input wire logic [64:0]  port_rate_cap_10g,
  input wire logic [34:0]  internal_port_id
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Outputs lag by one edge, so the edge right after reset is skipped.
  sequence s_live;
    $past(rstn);
  endsequence
  a_fixed_lane: assert property (s_live |-> lane_port[6:0] == port_map_pkg::FIXED_PORT)
    else $error("lane 0 lost its port");
  a_quad_route: assert property ($past(rstn && quad_ena[0] && !multi_ena[13]) |->
    lane_src[41:39] == 3'h3 && lane_port[97:91] == 7'h00) else $error("quad route wrong");
  a_octal_prio: assert property ($past(rstn && octal_ena[0] && !multi_ena[17]) |->
    lane_src[53:51] == 3'h4) else $error("octal priority wrong");
  a_multi_prio: assert property ($past(rstn && multi_ena[17]) |->
    lane_src[53:51] == 3'h5 && lane_port[125:119] == 7'h30) else $error("multi wrong");
  a_shadow_route: assert property ($past(rstn && shadow_select_field[0] && !multi_ena[1])
    |-> lane_src[5:3] == 3'h2) else $error("shadow not routed");
  a_fast_route: assert property ($past(rstn && !shadow_select_field[0] && !multi_ena[1])
    |-> lane_src[5:3] == 3'h1 && lane_port[13:7] == 7'h00) else $error("fast not routed");
  a_internal_ids: assert property (s_live |-> internal_port_id == {
    port_map_pkg::VD_TUNNEL, port_map_pkg::VD_INJECTOR, port_map_pkg::VD_MCAST,
    port_map_pkg::CPU_PORT_B, port_map_pkg::CPU_PORT_A}) else $error("internal ids wrong");
  a_rate_cap: assert property (s_live |-> port_rate_cap_10g == 65'h0_FF00_0000_0000_0000)
    else $error("rate cap wrong");
endmodule
bind port_to_serdes_mapper mapper_chk u_chk (.sys_clk, .rstn, .shadow_select_field,
  .quad_ena, .octal_ena, .multi_ena, .lane_port, .lane_src, .port_rate_cap_10g,
  .internal_port_id);
`default_nettype wire

//--- tb/lane_macro_model.sv
// Lane macro side model: raises fiber requests one edge after being told.
`timescale 1ns/1ns
`default_nettype none
module lane_macro_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [32:0] want,
  output var  logic [32:0] fiber_100m_req
);
  // It asks on every lane it is told to, so the mapper must do the refusing.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) fiber_100m_req <= '0;
    else fiber_100m_req <= want;
  end
endmodule
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the port to lane mapper.
`timescale 1ns/1ns
`default_nettype none
module tb;
  typedef struct {int l; logic [11:0] q; logic [5:0] o; logic [32:0] m; logic s;
    logic [6:0] p; logic [2:0] c;} row_t;
  logic sys_clk = 0, rstn = 0, s0 = 0;
  logic [11:0] quad_ena = '0;
  logic [5:0] octal_ena = '0;
  logic [32:0] multi_ena = '0, want = '0, fiber_100m_req, fiber_100m_mode;
  logic [230:0] lane_port;
  logic [98:0] lane_src;
  logic [65:0] lane_speed_max, sm;
  logic [64:0] port_connected, shadow_active;
  logic [129:0] port_speed_class, pc;
  logic [34:0] internal_port_id;
  int fails = 0, n_tests = 0;
  row_t rows [10] = '{'{1, '0, '0, '0, 1'b0, 7'h00, 3'h1}, '{1, '0, '0, '0, 1'b1, 7'h00, 3'h2},
    '{13, '0, '0, '0, 1'b0, 7'h0C, 3'h1}, '{13, 12'h001, '0, '0, 1'b0, 7'h00, 3'h3},
    '{17, 12'h010, '0, '0, 1'b0, 7'h10, 3'h3}, '{17, 12'h010, 6'h01, '0, 1'b0, 7'h00, 3'h4},
    '{17, 12'h010, 6'h01, 33'h0_0002_0000, 1'b0, 7'h30, 3'h5},
    '{1, '0, '0, 33'h0_0000_0002, 1'b1, 7'h00, 3'h5}, '{32, '0, '0, '0, 1'b0, 7'h3F, 3'h1},
    '{0, 12'hFFF, 6'h3F, 33'h1_FFFF_FFFF, 1'b0, 7'h40, 3'h1}};
  port_to_serdes_mapper u_port_to_serdes_mapper (.sys_clk(sys_clk), .rstn(rstn),
    .shadow_select_field({64'h0, s0}), .quad_ena(quad_ena), .octal_ena(octal_ena),
    .multi_ena(multi_ena), .multi_mode('0), .fiber_100m_req(fiber_100m_req),
    .lane_port(lane_port), .lane_src(lane_src), .lane_speed_max(lane_speed_max),
    .fiber_100m_mode(fiber_100m_mode), .shadow_active(shadow_active),
    .port_connected(port_connected), .port_speed_class(port_speed_class),
    .port_rate_cap_10g(), .internal_port_id(internal_port_id));
  lane_macro_model u_lane_macro_model (.sys_clk(sys_clk), .rstn(rstn), .want(want),
    .fiber_100m_req(fiber_100m_req));
  initial forever #5 sys_clk = ~sys_clk;
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input logic [255:0] seen, input logic [255:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    tick(6);
    rstn = 1;
    foreach (rows[i]) begin
      quad_ena = rows[i].q;
      octal_ena = rows[i].o;
      multi_ena = rows[i].m;
      s0 = rows[i].s;
      tick(2);
      chk(lane_port[7*rows[i].l +: 7], rows[i].p);
      chk(lane_src[3*rows[i].l +: 3], rows[i].c);
      $display("row %0d done", i);
    end
    rstn = 0;
    tick(1);
    chk(lane_port, '0);
    chk(lane_src, '0);
    quad_ena = '0;
    octal_ena = '0;
    multi_ena = '0;
    want = '1;
    tick(1);
    rstn = 1;
    tick(3);
    chk(port_connected, 65'h1_FFFF_0000_0000_FFFF);
    chk(fiber_100m_mode, 33'h0_01FF_FFFE);
    for (int k = 0; k < 65; k++) begin
      if (k < 33) sm[2*k +: 2] = (k < 13) ? 2'h1 : 2'h2;
      pc[2*k +: 2] = (k < 12 || k == 64) ? 2'h1 : (k > 15 && k < 48) ? 2'h0 : 2'h2;
    end
    chk(lane_speed_max, sm);
    chk(port_speed_class, pc);
    s0 = 1;
    tick(2);
    chk(shadow_active, 65'h0_0000_0000_0000_0001);
    s0 = 0;
    quad_ena = 12'h001;
    tick(2);
    chk(fiber_100m_mode, 33'h0_01FF_DFFE);
    chk(port_connected, 65'h1_FFFF_0000_0000_EFFF);
    $display("reset and fiber tests done");
    print_verdict();
  end
endmodule
`default_nettype wire
